// *** hw/ohb_front_end.sv ***
// Host bus front end: strap-selected SPI, I2C, 8080 or 6800 byte receiver.
`timescale 1ns/100ps
`default_nettype none
module ohb_front_end
  import ohb_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  // Straps and control pins
  input wire logic bus_sel_lo_i,
  input wire logic bus_sel_hi_i,
  input wire logic cs_n_i,
  input wire logic hw_init_n_i,
  input wire logic dc_i,
  input wire logic rw_wr_n_i,
  input wire logic rd_e_i,
  // Data pins
  input wire logic [7:0] d_i,
  output logic [7:0] d_o,
  output logic [7:0] d_oe_o,
  // Read path from the core
  input wire logic [7:0] rd_data_i,
  output logic rd_req_o,
  // Received bytes
  output logic [7:0] data_o,
  output logic data_valid_o,
  output logic [7:0] cmd_reg_o,
  output logic cmd_valid_o,
  // Status
  output logic [1:0] mode_o,
  output logic init_busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  ohb_mode_t mode_reg;
  logic strap_done_reg;
  logic is_spi, is_i2c, is_8080, is_6800;
  logic [EDGE_W-1:0] lvl, prev, rise, fall;
  logic sclk_rise, scl_fall, scl_hi, i2c_start, i2c_stop;
  logic wr_fall, wr_rise, e_rise, e_fall;

  // Straps follow the pins while init is held, then freeze
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_reg <= OHB_SPI;
      strap_done_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (!hw_init_n_i || !strap_done_reg) begin
        mode_reg <= ohb_mode_t'({bus_sel_hi_i, bus_sel_lo_i});
        strap_done_reg <= 1'b1;
      end
    end
  end

  // Exactly one front end live; nothing live before the straps are caught
  assign is_spi = strap_done_reg && (mode_reg == OHB_SPI);
  assign is_i2c = strap_done_reg && (mode_reg == OHB_I2C);
  assign is_8080 = strap_done_reg && (mode_reg == OHB_P8080);
  assign is_6800 = strap_done_reg && (mode_reg == OHB_P6800);

  assign lvl = {rd_e_i, rw_wr_n_i, d_i[PIN_SERIAL_IN], d_i[PIN_SCLK]};

  ohb_edge #(
    .W(EDGE_W)
  ) u_edge (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .clk_en_i(clk_en_i),
    .lvl_i(lvl),
    .prev_o(prev),
    .rise_o(rise),
    .fall_o(fall)
  );

  assign sclk_rise = rise[EDGE_D0];
  assign scl_fall = fall[EDGE_D0];
  assign scl_hi = d_i[PIN_SCLK] && prev[EDGE_D0];
  assign i2c_start = scl_hi && fall[EDGE_D1];
  assign i2c_stop = scl_hi && rise[EDGE_D1];
  assign wr_fall = fall[EDGE_WR];
  assign wr_rise = rise[EDGE_WR];
  assign e_rise = rise[EDGE_RD];
  assign e_fall = fall[EDGE_RD];

  ////////////////////////////////////////////////////////////////////////////
  // Serial receivers share one shifter; only one mode is ever live
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  ohb_i2c_st_t i2c_st_reg;
  ohb_kind_t kind_reg;
  logic i2c_dc_reg, co_reg, ack_oe_reg;
  logic i2c_byte_end, addr_ok;

  assign i2c_byte_end = (i2c_st_reg == I2C_RX) && scl_fall && (bit_cnt_reg == BYTE_BITS);
  assign addr_ok = (shift_reg[7:1] == {I2C_ADDR_HI, dc_i}) && !shift_reg[0];

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      i2c_st_reg <= I2C_IDLE;
      kind_reg <= KIND_ADDR;
      i2c_dc_reg <= 1'b0;
      co_reg <= 1'b0;
      ack_oe_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (!hw_init_n_i || cs_n_i) begin
        bit_cnt_reg <= 4'h0;
        i2c_st_reg <= I2C_IDLE;
        ack_oe_reg <= 1'b0;
      end else if (is_spi) begin
        if (sclk_rise) begin
          shift_reg <= {shift_reg[6:0], d_i[PIN_SERIAL_IN]};
          bit_cnt_reg <= (bit_cnt_reg == BIT_LAST) ? 4'h0 : 4'(bit_cnt_reg + 4'h1);
        end
      end else if (is_i2c) begin
        if (i2c_start) begin
          i2c_st_reg <= I2C_RX;
          kind_reg <= KIND_ADDR;
          bit_cnt_reg <= 4'h0;
          ack_oe_reg <= 1'b0;
        end else if (i2c_stop) begin
          i2c_st_reg <= I2C_IDLE;
          ack_oe_reg <= 1'b0;
        end else begin
          unique case (i2c_st_reg)
            I2C_IDLE: begin
            end
            I2C_RX: begin
              if (rise[EDGE_D0] && bit_cnt_reg != BYTE_BITS) begin
                shift_reg <= {shift_reg[6:0], d_i[PIN_SERIAL_IN]};
                bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
              end else if (i2c_byte_end) begin
                bit_cnt_reg <= 4'h0;
                unique case (kind_reg)
                  KIND_ADDR: begin
                    // Reads are not offered: a read address is not acknowledged
                    i2c_st_reg <= addr_ok ? I2C_ACK : I2C_IDLE;
                    ack_oe_reg <= addr_ok;
                    kind_reg <= KIND_CTRL;
                  end
                  KIND_CTRL: begin
                    i2c_st_reg <= I2C_ACK;
                    ack_oe_reg <= 1'b1;
                    i2c_dc_reg <= shift_reg[CTRL_DC_BIT];
                    co_reg <= shift_reg[CTRL_CO_BIT];
                    kind_reg <= KIND_DATA;
                  end
                  KIND_DATA: begin
                    i2c_st_reg <= I2C_ACK;
                    ack_oe_reg <= 1'b1;
                    kind_reg <= co_reg ? KIND_CTRL : KIND_DATA;
                  end
                endcase
              end
            end
            I2C_ACK: begin
              if (scl_fall) begin
                ack_oe_reg <= 1'b0;
                i2c_st_reg <= I2C_RX;
              end
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parallel strobes
  logic p_wr_start, p_wr_end, p_rd_start, p_rd_end;
  logic wr_pend_reg, rd_act_reg;

  always_comb begin
    p_wr_start = 1'b0;
    p_wr_end = 1'b0;
    p_rd_start = 1'b0;
    p_rd_end = cs_n_i;
    if (is_8080) begin
      p_wr_start = wr_fall && !cs_n_i;
      p_wr_end = wr_rise && wr_pend_reg && !cs_n_i;
      p_rd_start = fall[EDGE_RD] && !cs_n_i;
      p_rd_end = p_rd_end || rise[EDGE_RD];
    end else if (is_6800) begin
      p_wr_start = e_rise && !cs_n_i && !rw_wr_n_i;
      p_wr_end = e_fall && wr_pend_reg && !cs_n_i;
      p_rd_start = e_rise && !cs_n_i && rw_wr_n_i;
      p_rd_end = p_rd_end || e_fall;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_pend_reg <= 1'b0;
      rd_act_reg <= 1'b0;
      rd_req_o <= 1'b0;
    end else if (clk_en_i) begin
      rd_req_o <= hw_init_n_i && p_rd_start;
      if (!hw_init_n_i) begin
        wr_pend_reg <= 1'b0;
        rd_act_reg <= 1'b0;
      end else begin
        // Data is taken at the closing edge, when the host has it settled
        wr_pend_reg <= p_wr_start || (wr_pend_reg && !p_wr_end && !cs_n_i);
        rd_act_reg <= p_rd_start || (rd_act_reg && !p_rd_end);
      end
    end
  end

  // Pins are one flop behind the read state; the bus turns round late, not early
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      d_o <= 8'h00;
      d_oe_o <= 8'h00;
    end else if (clk_en_i) begin
      if (!hw_init_n_i) begin
        d_o <= 8'h00;
        d_oe_o <= 8'h00;
      end else begin
        if (p_rd_start) begin
          d_o <= rd_data_i;
        end else if (!rd_act_reg) begin
          d_o <= 8'h00;
        end
        d_oe_o <= ack_oe_reg ? SDA_OUT_MASK : (rd_act_reg ? ALL_ONES : 8'h00);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte delivery
  logic byte_stb, byte_dc;
  logic [7:0] byte_val;

  always_comb begin
    byte_stb = 1'b0;
    byte_dc = dc_i;
    byte_val = d_i;
    if (is_spi) begin
      byte_stb = !cs_n_i && sclk_rise && (bit_cnt_reg == BIT_LAST);
      byte_val = {shift_reg[6:0], d_i[PIN_SERIAL_IN]};
    end else if (is_i2c) begin
      byte_stb = !cs_n_i && i2c_byte_end && (kind_reg == KIND_DATA);
      byte_dc = i2c_dc_reg;
      byte_val = shift_reg;
    end else begin
      byte_stb = p_wr_end;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_o <= 8'h00;
      data_valid_o <= 1'b0;
      cmd_reg_o <= 8'h00;
      cmd_valid_o <= 1'b0;
    end else if (clk_en_i) begin
      data_valid_o <= 1'b0;
      cmd_valid_o <= 1'b0;
      if (!hw_init_n_i) begin
        data_o <= 8'h00;
        cmd_reg_o <= 8'h00;
      end else if (byte_stb && byte_dc) begin
        data_o <= byte_val;
        data_valid_o <= 1'b1;
      end else if (byte_stb) begin
        cmd_reg_o <= byte_val;
        cmd_valid_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_o <= 2'h0;
      init_busy_o <= 1'b1;
    end else if (clk_en_i) begin
      mode_o <= mode_reg;
      init_busy_o <= !hw_init_n_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i || !clk_en_i);

  a_strap_decode: assert property (!hw_init_n_i
    |=> mode_reg == ohb_mode_t'($past({bus_sel_hi_i, bus_sel_lo_i})))
    else $error("strap value not decoded");
  a_cs_gate: assert property (cs_n_i |-> !byte_stb ##1 !data_valid_o && !cmd_valid_o)
    else $error("byte taken with chip deselected");
  a_init_clear: assert property (!hw_init_n_i
    |=> init_busy_o && !data_valid_o && !cmd_valid_o && d_oe_o == 8'h00)
    else $error("init does not quiet the front end");
  a_data_route: assert property (byte_stb && byte_dc && hw_init_n_i
    |=> data_valid_o && !cmd_valid_o && data_o == $past(byte_val))
    else $error("data byte misrouted");
  a_cmd_route: assert property (byte_stb && !byte_dc && hw_init_n_i
    |=> cmd_valid_o && !data_valid_o && cmd_reg_o == $past(byte_val))
    else $error("command byte misrouted");
  a_i2c_addr: assert property (is_i2c && !cs_n_i && hw_init_n_i && !i2c_start && !i2c_stop
    && i2c_byte_end && kind_reg == KIND_ADDR |=> ack_oe_reg == $past(addr_ok))
    else $error("address match wrong");
  a_6800_read: assert property (is_6800 && hw_init_n_i && e_rise && !cs_n_i && rw_wr_n_i
    |=> rd_req_o ##1 d_oe_o == ALL_ONES)
    else $error("6800 read not started");
  a_8080_write: assert property (is_8080 && hw_init_n_i && wr_fall && !cs_n_i
    |=> wr_pend_reg && !rd_req_o)
    else $error("8080 write not started");
  a_spi_shift: assert property (is_spi && hw_init_n_i && !cs_n_i && sclk_rise
    |=> shift_reg[0] == $past(d_i[PIN_SERIAL_IN]))
    else $error("serial input not shifted");
  a_i2c_ack_pin: assert property (is_i2c && ack_oe_reg && hw_init_n_i
    |=> d_oe_o == SDA_OUT_MASK && d_o == 8'h00)
    else $error("acknowledge not on sda output");
  a_one_front: assert property (!is_8080 && !is_6800 |-> !p_wr_start && !p_rd_start && !p_wr_end)
    else $error("parallel strobe seen in serial mode");

  c_spi_data: cover property (is_spi ##1 data_valid_o);
  c_i2c_ack: cover property (is_i2c && ack_oe_reg && kind_reg == KIND_DATA);
  c_6800_read: cover property (is_6800 && rd_req_o);
  c_8080_cmd: cover property (is_8080 && cmd_valid_o);
endmodule
`default_nettype wire

// *** inc/ohb_pkg.sv ***
// Constants, types and pin map of the display host bus front end.
package ohb_pkg;

  typedef enum logic [1:0] {
    OHB_SPI = 2'h0,
    OHB_I2C = 2'h1,
    OHB_P6800 = 2'h2,
    OHB_P8080 = 2'h3
  } ohb_mode_t;

  typedef enum {I2C_IDLE, I2C_RX, I2C_ACK} ohb_i2c_st_t;
  typedef enum {KIND_ADDR, KIND_CTRL, KIND_DATA} ohb_kind_t;

  // Data pin roles in the serial modes
  localparam int unsigned PIN_SCLK = 0;
  localparam int unsigned PIN_SERIAL_IN = 1;
  localparam int unsigned PIN_SDA_OUT = 2;
  localparam logic [7:0] SDA_OUT_MASK = 8'h04;
  localparam logic [7:0] ALL_ONES = 8'hFF;

  // Edge detector lanes
  localparam int unsigned EDGE_W = 4;
  localparam int unsigned EDGE_D0 = 0;
  localparam int unsigned EDGE_D1 = 1;
  localparam int unsigned EDGE_WR = 2;
  localparam int unsigned EDGE_RD = 3;

  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // I2C address bits above the strap-selected bit; plain default
  localparam logic [5:0] I2C_ADDR_HI = 6'h1E;
  localparam int unsigned CTRL_CO_BIT = 7;
  localparam int unsigned CTRL_DC_BIT = 6;

endpackage

// *** hw/ohb_edge.sv ***
// Registered edge detector for a group of synchronous levels.
`timescale 1ns/100ps
`default_nettype none
module ohb_edge #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  // Levels and edges
  input wire logic [W-1:0] lvl_i,
  output logic [W-1:0] prev_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  logic [W-1:0] prev_reg;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_reg <= '0;
    end else if (clk_en_i) begin
      prev_reg <= lvl_i;
    end
  end

  assign prev_o = prev_reg;
  assign rise_o = lvl_i & ~prev_reg;
  assign fall_o = ~lvl_i & prev_reg;
endmodule
`default_nettype wire

// *** dv/ohb_host_model.sv ***
// Host microcontroller model that drives the front end's pins.
`timescale 1ns/100ps
`default_nettype none
module ohb_host_model (
  // Clock
  input wire logic sys_clk_i,
  // Pins towards the device
  output logic bus_sel_lo_o,
  output logic bus_sel_hi_o,
  output logic cs_n_o,
  output logic hw_init_n_o,
  output logic dc_o,
  output logic rw_wr_n_o,
  output logic rd_e_o,
  output logic [7:0] d_pin_o,
  // Device side of the data pins
  input wire logic [7:0] d_o_i,
  input wire logic [7:0] d_oe_i
);
  logic [7:0] host_d;
  logic sda_low;
  logic i2c_on;
  logic sda;
  ////////////////////////////////////////////////////////////////
  // Open drain with pull-up: D1 and D2 form one wire
  assign sda = !(sda_low || (d_oe_i[2] && !d_o_i[2]));
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      d_pin_o[i] = d_oe_i[i] ? d_o_i[i] : host_d[i];
    end
    if (i2c_on) begin
      d_pin_o[1] = sda;
      d_pin_o[2] = sda;
    end
  end
  initial begin
    {bus_sel_hi_o, bus_sel_lo_o} = 2'h3;
    cs_n_o = 1'b1;
    hw_init_n_o = 1'b1;
    dc_o = 1'b0;
    rw_wr_n_o = 1'b1;
    rd_e_o = 1'b1;
    host_d = 8'h00;
    sda_low = 1'b0;
    i2c_on = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // Every level stands at least two cycles so the edge detector sees it
  task step(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task set_init(input logic low, input logic [1:0] sel);
    hw_init_n_o = !low;
    {bus_sel_hi_o, bus_sel_lo_o} = sel;
    i2c_on = (sel == 2'h1);
    rw_wr_n_o = (sel == 2'h3);
    rd_e_o = (sel == 2'h3);
    step(3);
  endtask
  task par_write(input logic p68, input logic csn, input logic dcv, input logic [7:0] b);
    cs_n_o = csn;
    dc_o = dcv;
    host_d = b;
    step(2);
    rw_wr_n_o = 1'b0;
    if (p68) rd_e_o = 1'b1;
    step(2);
    if (p68) rd_e_o = 1'b0;
    else rw_wr_n_o = 1'b1;
    step(2);
    cs_n_o = 1'b1;
    step(2);
  endtask
  task par_read(input logic p68, output logic [7:0] got);
    cs_n_o = 1'b0;
    // Released lines show the inverse of their last value
    host_d = ~host_d;
    step(2);
    if (p68) begin
      rw_wr_n_o = 1'b1;
      rd_e_o = 1'b1;
    end else rd_e_o = 1'b0;
    step(3);
    got = d_pin_o;
    step(1);
    rd_e_o = !p68;
    step(2);
    rw_wr_n_o = !p68;
    cs_n_o = 1'b1;
    step(3);
  endtask
  task spi_byte(input logic dcv, input logic [7:0] b);
    cs_n_o = 1'b0;
    dc_o = dcv;
    for (int i = 7; i >= 0; i--) begin
      host_d[1] = b[i];
      host_d[0] = 1'b0;
      step(2);
      host_d[0] = 1'b1;
      step(2);
    end
    host_d[0] = 1'b0;
    step(2);
    cs_n_o = 1'b1;
    step(2);
  endtask
  task i2c_start(input logic sa0);
    cs_n_o = 1'b0;
    dc_o = sa0;
    sda_low = 1'b0;
    host_d[0] = 1'b1;
    step(2);
    sda_low = 1'b1;
    step(2);
    host_d[0] = 1'b0;
    step(2);
  endtask
  task i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = !b[i];
      step(2);
      host_d[0] = 1'b1;
      step(2);
      host_d[0] = 1'b0;
      step(2);
    end
    sda_low = 1'b0;
    host_d[0] = 1'b1;
    step(1);
    ack = !sda;
    step(1);
    host_d[0] = 1'b0;
    step(2);
  endtask
  task i2c_stop();
    sda_low = 1'b1;
    step(2);
    host_d[0] = 1'b1;
    step(2);
    sda_low = 1'b0;
    step(2);
    // Deselect stands two cycles so a following start sees it
    cs_n_o = 1'b1;
    step(2);
  endtask
endmodule
`default_nettype wire

// *** dv/ohb_testbench.sv ***
// Self-checking testbench of the host bus front end in all four modes.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (g), (e)); end end
module testbench
  import ohb_pkg::*;
;
  logic sys_clk_i, resetn_i, bus_sel_lo, bus_sel_hi, cs_n, hw_init_n, dc, rw_wr_n, rd_e;
  logic rd_req_o, data_valid_o, cmd_valid_o, init_busy_o, ack;
  logic [7:0] d_i, d_o, d_oe_o, rd_data_i, data_o, cmd_reg_o, got;
  logic [1:0] mode_o;
  int mismatches = 0, checks_done = 0, n_data = 0, n_cmd = 0, n_rd = 0, ed = 0, ec = 0, er = 0;
  ohb_front_end ohb_front_end_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .clk_en_i(1'b1),
    .bus_sel_lo_i(bus_sel_lo), .bus_sel_hi_i(bus_sel_hi), .cs_n_i(cs_n), .hw_init_n_i(hw_init_n),
    .dc_i(dc), .rw_wr_n_i(rw_wr_n), .rd_e_i(rd_e), .d_i(d_i), .d_o(d_o), .d_oe_o(d_oe_o),
    .rd_data_i(rd_data_i), .rd_req_o(rd_req_o), .data_o(data_o), .data_valid_o(data_valid_o),
    .cmd_reg_o(cmd_reg_o), .cmd_valid_o(cmd_valid_o), .mode_o(mode_o), .init_busy_o(init_busy_o));
  ohb_host_model ohb_host_model_inst (.sys_clk_i(sys_clk_i), .bus_sel_lo_o(bus_sel_lo),
    .bus_sel_hi_o(bus_sel_hi), .cs_n_o(cs_n), .hw_init_n_o(hw_init_n), .dc_o(dc), .rw_wr_n_o(rw_wr_n),
    .rd_e_o(rd_e), .d_pin_o(d_i), .d_o_i(d_o), .d_oe_i(d_oe_o));
  ////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // Pulses are counted so a missing or doubled delivery shows up
  always @(posedge sys_clk_i) begin
    if (data_valid_o === 1'b1) n_data++;
    if (cmd_valid_o === 1'b1) n_cmd++;
    if (rd_req_o === 1'b1) n_rd++;
  end
  task results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task rx(input logic [7:0] dv, input logic [7:0] cv);
    `CHK(n_data, ed)
    `CHK(n_cmd, ec)
    `CHK(data_o, dv)
    `CHK(cmd_reg_o, cv)
  endtask
  task set_mode(input logic [1:0] m);
    ohb_host_model_inst.set_init(1'b1, m);
    `CHK(init_busy_o, 1'b1)
    `CHK(cmd_reg_o, 8'h00)
    `CHK(data_o, 8'h00)
    ohb_host_model_inst.set_init(1'b0, m);
    `CHK(init_busy_o, 1'b0)
    `CHK(mode_o, m)
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    mismatches++;
    results();
  end
  initial begin
    resetn_i = 1'b0;
    rd_data_i = 8'h00;
    repeat (2) @(negedge sys_clk_i);
    `CHK(init_busy_o, 1'b1)
    resetn_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    for (int m = 0; m < 4; m++) set_mode(m[1:0]);
    ohb_host_model_inst.par_write(1'b0, 1'b0, 1'b0, 8'hA5);
    ec++;
    rx(8'h00, 8'hA5);
    ohb_host_model_inst.par_write(1'b0, 1'b0, 1'b1, 8'h3C);
    ed++;
    rx(8'h3C, 8'hA5);
    ohb_host_model_inst.par_write(1'b0, 1'b1, 1'b1, 8'hFF);
    rx(8'h3C, 8'hA5);
    rd_data_i = 8'h96;
    ohb_host_model_inst.par_read(1'b0, got);
    er++;
    `CHK(got, 8'h96)
    `CHK(n_rd, er)
    set_mode(OHB_P6800);
    ohb_host_model_inst.par_write(1'b1, 1'b0, 1'b0, 8'h5A);
    ec++;
    rx(8'h00, 8'h5A);
    ohb_host_model_inst.par_write(1'b1, 1'b0, 1'b1, 8'hC3);
    ed++;
    rx(8'hC3, 8'h5A);
    rd_data_i = 8'h69;
    ohb_host_model_inst.par_read(1'b1, got);
    er++;
    `CHK(got, 8'h69)
    `CHK(n_rd, er)
    set_mode(OHB_SPI);
    ohb_host_model_inst.spi_byte(1'b0, 8'h81);
    ec++;
    rx(8'h00, 8'h81);
    ohb_host_model_inst.spi_byte(1'b1, 8'h7E);
    ed++;
    rx(8'h7E, 8'h81);
    ohb_host_model_inst.par_write(1'b1, 1'b0, 1'b0, 8'hA4);
    rx(8'h7E, 8'h81);
    set_mode(OHB_I2C);
    ohb_host_model_inst.i2c_start(1'b0);
    ohb_host_model_inst.i2c_byte(8'h78, ack);
    `CHK(ack, 1'b1)
    ohb_host_model_inst.i2c_byte(8'h80, ack);
    `CHK(ack, 1'b1)
    ohb_host_model_inst.i2c_byte(8'hA5, ack);
    `CHK(ack, 1'b1)
    ec++;
    rx(8'h00, 8'hA5);
    ohb_host_model_inst.i2c_byte(8'h40, ack);
    ohb_host_model_inst.i2c_byte(8'h3C, ack);
    `CHK(ack, 1'b1)
    ed++;
    rx(8'h3C, 8'hA5);
    ohb_host_model_inst.i2c_stop();
    ohb_host_model_inst.i2c_start(1'b1);
    ohb_host_model_inst.i2c_byte(8'h78, ack);
    `CHK(ack, 1'b0)
    ohb_host_model_inst.i2c_stop();
    ohb_host_model_inst.i2c_start(1'b1);
    ohb_host_model_inst.i2c_byte(8'h7A, ack);
    `CHK(ack, 1'b1)
    ohb_host_model_inst.i2c_stop();
    // Read address is never acknowledged and delivers nothing
    ohb_host_model_inst.i2c_start(1'b0);
    ohb_host_model_inst.i2c_byte(8'h79, ack);
    `CHK(ack, 1'b0)
    ohb_host_model_inst.i2c_stop();
    rx(8'h3C, 8'hA5);
    results();
  end
endmodule
`default_nettype wire
